// *** logic/pll_cfg_pkg.sv ***
// constants for the three-pll synthesizer configuration block
// assumes a byte-wide register port fed by an smbus slave engine elsewhere
package pll_cfg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_BYTES = 27;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_ID = 5'h00;
    localparam logic [4:0] OFS_PLL1_M = 5'h01;
    localparam logic [4:0] OFS_PLL1_N = 5'h02;
    localparam logic [4:0] OFS_BYPASS = 5'h03;
    localparam logic [4:0] OFS_PLL2_M = 5'h04;
    localparam logic [4:0] OFS_PLL2_N = 5'h05;
    localparam logic [4:0] OFS_RANGE = 5'h06;
    localparam logic [4:0] OFS_PLL3_M = 5'h07;
    localparam logic [4:0] OFS_PLL3_N = 5'h08;
    localparam logic [4:0] OFS_SEL_P0 = 5'h09;
    localparam logic [4:0] OFS_CTL = 5'h0A;
    localparam logic [4:0] OFS_SRC = 5'h0B;
    localparam logic [4:0] OFS_PWR = 5'h0C;
    localparam logic [4:0] OFS_SSC = 5'h19;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HI_SEL_LSB = 5;      // bits 7:5 of bytes 3, 6, 9, 10
    localparam int N_HI_LSB = 1;        // n[11:8] in bits 4:1
    localparam int M_MSB_BIT = 0;       // m[8] in bit 0
    localparam int CLKSEL_BIT = 4;
    localparam int BCFG_LSB = 2;
    localparam int ACFG_LSB = 0;
    localparam int SRC_LSB = 6;
    localparam int PD_BIT = 6;
    localparam int SSC_MOD_LSB = 4;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_MID_LSB = 3;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACFG_POWER_DOWN = 2'h0;
    localparam logic [1:0] ACFG_TEST_BYPASS = 2'h1;
    localparam logic [1:0] ACFG_CLK_SELECT = 2'h2;
    localparam logic [1:0] BCFG_FORCE_LOW = 2'h0;
    localparam logic [1:0] BCFG_HIZ = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL = 2'h0;
    localparam logic [1:0] SRC_SINGLE = 2'h1;
    localparam logic [1:0] SRC_DIFF = 2'h2;

    // ------------------------------------------------------------
    // power-up values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PLL1_M = 8'h01;
    localparam logic [7:0] RST_PLL1_N = 8'h08;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RST_PLL2_M = 8'h1B;
    localparam logic [7:0] RST_PLL2_N = 8'hFA;
    localparam logic [7:0] RST_RANGE = 8'hE0;
    localparam logic [7:0] RST_PLL3_M = 8'h77;
    localparam logic [7:0] RST_PLL3_N = 8'h40;
    localparam logic [7:0] RST_SEL_P0 = 8'h59;
    localparam logic [7:0] RST_CTL = 8'h80;
    localparam logic [7:0] RST_SRC = 8'h09;
    localparam logic [7:0] RST_PWR = 8'h09;

    function automatic logic [7:0] reset_byte(input int idx);
        case (idx)
            1: reset_byte = RST_PLL1_M;
            2: reset_byte = RST_PLL1_N;
            3: reset_byte = RST_BYPASS;
            4: reset_byte = RST_PLL2_M;
            5: reset_byte = RST_PLL2_N;
            6: reset_byte = RST_RANGE;
            7: reset_byte = RST_PLL3_M;
            8: reset_byte = RST_PLL3_N;
            9: reset_byte = RST_SEL_P0;
            10: reset_byte = RST_CTL;
            11: reset_byte = RST_SRC;
            12: reset_byte = RST_PWR;
            default: reset_byte = 8'h00;
        endcase
    endfunction

endpackage

// *** logic/cfg_byte_store.sv ***
// byte-wide configuration store with registered read data
// assumes writes and reads arrive on ref_clk from the smbus engine
`timescale 1ns/100ps
`default_nettype none
module cfg_byte_store #(
    parameter int DEPTH = pll_cfg_pkg::NUM_BYTES,
    parameter int AW = pll_cfg_pkg::ADDR_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_reg,
    output logic [DEPTH*8-1:0] bytes_flat
);
    logic [7:0] mem_reg [DEPTH];

    // ------------------------------------------------------------
    // storage; byte 0 is never written here
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!rst_n) begin
                mem_reg[i] <= pll_cfg_pkg::reset_byte(i);
            end else if (wr_en && i != 0 && int'(addr) == i) begin
                mem_reg[i] <= wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (rd_en) begin
            rdata_reg <= (int'(addr) < DEPTH) ? mem_reg[addr] : 8'h00;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            bytes_flat[i*8 +: 8] = mem_reg[i];
        end
    end
endmodule
`default_nettype wire

// *** logic/pll_synth_config_control.sv ***
// configuration and control decode of a three-pll clock synthesizer
// assumes an smbus slave engine on ref_clk drives the byte register port
//
// What this block does
// - read-only id byte: maker code in bits 3:0, revision in 7:4
// - id byte answers only single-byte reads; host must not block-read it
// - all other bytes are writable and read back the last written value
// - 9-bit reference dividers, ratio 1..511, defaults 1, 27, 375
// - 12-bit feedback dividers, ratio 1..4095, defaults 8, 250, 3136
// - byte 3 bits 7:5 bypass each vco when set, default zero
// - byte 6 bits 7:5 pick high vco range when set, default one
// - six 3-bit post-divider source selectors with documented defaults
// - ssc bypass powers down pll2 spread path, holds its output low
// - control a code 00 low: power down plls, input stage, outputs hi-z
// - control a code 01 low: bypass pll and dividers, outputs stay active
// - control a code 10: its level picks input clock over register bit
// - power-down from control a beats control b hi-z or force-low
// - input clock pick has no effect in crystal or differential mode
// - source field: 00 crystal, 01 two single-ended, 10 differential
`timescale 1ns/100ps
`default_nettype none
module pll_synth_config_control #(
    parameter logic [3:0] MAKER_CODE = 4'h5,      // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h2,   // arbitrary value
    parameter logic [2:0] SSC_BYPASS_CODE = 3'h0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic reg_rd_single,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic control_input_a,
    input wire logic control_input_b,
    output logic [26:0] pll_ref_div,
    output logic [35:0] pll_fb_div,
    output logic [2:0] vco_bypass_bit,
    output logic [2:0] vco_range_bit,
    output logic [17:0] postdiv_source_sel,
    output logic [2:0] pll_power_down,
    output logic input_stage_power_down,
    output logic full_bypass,
    output logic outputs_hiz,
    output logic outputs_force_low,
    output logic clock_input_one_sel,
    output logic crystal_mode,
    output logic differential_mode,
    output logic ssc_power_down,
    output logic ssc_out_hold_low
);
    localparam int NB = pll_cfg_pkg::NUM_BYTES;

    logic [NB*8-1:0] bytes_flat;
    logic [7:0] store_rdata;
    logic a_meta_reg, a_sync_reg, b_meta_reg, b_sync_reg;
    logic id_read_reg, blank_read_reg;

    function automatic logic [7:0] byte_at(input logic [NB*8-1:0] v, input logic [4:0] ofs);
        byte_at = v[ofs*8 +: 8];
    endfunction

    cfg_byte_store #(
        .DEPTH(NB),
        .AW(pll_cfg_pkg::ADDR_W)
    ) u_store (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(reg_wr_en),
        .rd_en(reg_rd_en),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .rdata_reg(store_rdata),
        .bytes_flat(bytes_flat)
    );

    // ------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rd_valid <= 1'b0;
            id_read_reg <= 1'b0;
            blank_read_reg <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            id_read_reg <= reg_rd_en && reg_addr == pll_cfg_pkg::OFS_ID && reg_rd_single;
            // block read of byte 0 returns zero
            blank_read_reg <= reg_rd_en && ((reg_addr == pll_cfg_pkg::OFS_ID && !reg_rd_single)
                || int'(reg_addr) >= NB);
        end
    end

    // other bytes read back from the store
    assign reg_rdata = id_read_reg ? {REVISION_CODE, MAKER_CODE} : (blank_read_reg ? 8'h00 : store_rdata);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a_meta_reg <= 1'b1;
            a_sync_reg <= 1'b1;
            b_meta_reg <= 1'b1;
            b_sync_reg <= 1'b1;
        end else begin
            a_meta_reg <= control_input_a;
            a_sync_reg <= a_meta_reg;
            b_meta_reg <= control_input_b;
            b_sync_reg <= b_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // decode of configuration bytes
    // ------------------------------------------------------------
    logic [7:0] b_byp, b_rng, b_p0, b_ctl, b_src, b_pwr, b_ssc;
    logic [1:0] acfg, bcfg, src;
    logic pd_any, test_byp, single_mode;
    always_comb begin
        b_byp = byte_at(bytes_flat, pll_cfg_pkg::OFS_BYPASS);
        b_rng = byte_at(bytes_flat, pll_cfg_pkg::OFS_RANGE);
        b_p0 = byte_at(bytes_flat, pll_cfg_pkg::OFS_SEL_P0);
        b_ctl = byte_at(bytes_flat, pll_cfg_pkg::OFS_CTL);
        b_src = byte_at(bytes_flat, pll_cfg_pkg::OFS_SRC);
        b_pwr = byte_at(bytes_flat, pll_cfg_pkg::OFS_PWR);
        b_ssc = byte_at(bytes_flat, pll_cfg_pkg::OFS_SSC);
        acfg = b_ctl[pll_cfg_pkg::ACFG_LSB +: 2];
        bcfg = b_ctl[pll_cfg_pkg::BCFG_LSB +: 2];
        src = b_src[pll_cfg_pkg::SRC_LSB +: 2];
        // power down on control a low
        pd_any = (acfg == pll_cfg_pkg::ACFG_POWER_DOWN && !a_sync_reg) || b_pwr[pll_cfg_pkg::PD_BIT];
        // production-test bypass on control a low
        test_byp = acfg == pll_cfg_pkg::ACFG_TEST_BYPASS && !a_sync_reg;
        single_mode = src == pll_cfg_pkg::SRC_SINGLE;
    end

    // divider fields assemble from a low byte plus the high bits of a shared byte
    // reference and feedback dividers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pll_ref_div <= {9'h177, 9'h01B, 9'h001};
            pll_fb_div <= {12'hC40, 12'h0FA, 12'h008};
        end else begin
            for (int i = 0; i < 3; i++) begin
                pll_ref_div[i*9 +: 9] <= {bytes_flat[(3*i+3)*8 + pll_cfg_pkg::M_MSB_BIT],
                    bytes_flat[(3*i+1)*8 +: 8]};
                pll_fb_div[i*12 +: 12] <= {bytes_flat[(3*i+3)*8 + pll_cfg_pkg::N_HI_LSB +: 4],
                    bytes_flat[(3*i+2)*8 +: 8]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vco_bypass_bit <= 3'h0;
            vco_range_bit <= 3'h7;
            postdiv_source_sel <= 18'h09262;
        end else begin
            vco_bypass_bit <= {b_byp[5], b_byp[6], b_byp[7]};
            vco_range_bit <= {b_rng[5], b_rng[6], b_rng[7]};
            // post-divider sources p0..p5, three bits each
            postdiv_source_sel <= {b_pwr[pll_cfg_pkg::SEL_MID_LSB +: 3], b_pwr[pll_cfg_pkg::SEL_LO_LSB +: 3],
                b_src[pll_cfg_pkg::SEL_MID_LSB +: 3], b_src[pll_cfg_pkg::SEL_LO_LSB +: 3],
                b_ctl[pll_cfg_pkg::HI_SEL_LSB +: 3], b_p0[pll_cfg_pkg::HI_SEL_LSB +: 3]};
        end
    end

    // ------------------------------------------------------------
    // power, bypass and output state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pll_power_down <= 3'h0;
            input_stage_power_down <= 1'b0;
            full_bypass <= 1'b0;
            outputs_hiz <= 1'b0;
            outputs_force_low <= 1'b0;
            // byte 25 powers up as zero, so the reset decode matches the default byte
            ssc_power_down <= SSC_BYPASS_CODE == 3'h0;
            ssc_out_hold_low <= SSC_BYPASS_CODE == 3'h0;
        end else begin
            pll_power_down <= {3{pd_any || test_byp}};
            input_stage_power_down <= pd_any;
            full_bypass <= test_byp && !pd_any;
            // power-down wins over control b states
            outputs_hiz <= pd_any || (bcfg == pll_cfg_pkg::BCFG_HIZ && !b_sync_reg);
            outputs_force_low <= !pd_any && bcfg == pll_cfg_pkg::BCFG_FORCE_LOW && !b_sync_reg;
            // spread path off and low under ssc bypass
            ssc_power_down <= b_ssc[pll_cfg_pkg::SSC_MOD_LSB +: 3] == SSC_BYPASS_CODE || pd_any || test_byp;
            ssc_out_hold_low <= b_ssc[pll_cfg_pkg::SSC_MOD_LSB +: 3] == SSC_BYPASS_CODE || pd_any || test_byp;
        end
    end

    // the input pick is forced to zero outside single-ended mode so nothing downstream toggles
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_input_one_sel <= 1'b0;
            crystal_mode <= 1'b1;
            differential_mode <= 1'b0;
        end else begin
            crystal_mode <= src == pll_cfg_pkg::SRC_CRYSTAL;
            differential_mode <= src == pll_cfg_pkg::SRC_DIFF;
            // control a level overrides register bit
            // ignored in crystal or differential mode
            clock_input_one_sel <= single_mode && ((acfg == pll_cfg_pkg::ACFG_CLK_SELECT) ? a_sync_reg
                : b_ctl[pll_cfg_pkg::CLKSEL_BIT]);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_id_single_read;
        reg_rd_en && reg_rd_single && reg_addr == pll_cfg_pkg::OFS_ID;
    endsequence
    sequence s_write_then_read;
        reg_wr_en && reg_addr != pll_cfg_pkg::OFS_ID && int'(reg_addr) < NB ##1 !reg_wr_en && !reg_rd_en
            ##1 reg_rd_en && !reg_wr_en && reg_addr == $past(reg_addr, 2);
    endsequence

    a_id_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_id_single_read |=> reg_rd_valid && reg_rdata == {REVISION_CODE, MAKER_CODE})
        else $error("id byte read returned wrong value");
    a_id_block_blank: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd_en && !reg_rd_single && reg_addr == pll_cfg_pkg::OFS_ID |=> reg_rdata == 8'h00)
        else $error("id byte leaked through block read");
    a_rw_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_write_then_read |=> reg_rdata == $past(reg_wdata, 3))
        else $error("byte did not read back last write");
    a_ref_div_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == pll_cfg_pkg::OFS_PLL2_M ##1 !reg_wr_en |=> pll_ref_div[16:9] == $past(reg_wdata, 2))
        else $error("pll2 reference divider did not follow write");
    a_fb_div_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == pll_cfg_pkg::OFS_PLL3_N ##1 !reg_wr_en |=> pll_fb_div[31:24] == $past(reg_wdata, 2))
        else $error("pll3 feedback divider did not follow write");
    a_bypass_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        vco_bypass_bit[0] == $past(b_byp[7]) && vco_bypass_bit[2] == $past(b_byp[5]))
        else $error("vco bypass bit order wrong");
    a_range_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == pll_cfg_pkg::OFS_RANGE ##1 !reg_wr_en
            |=> vco_range_bit == {$past(reg_wdata[5], 2), $past(reg_wdata[6], 2), $past(reg_wdata[7], 2)})
        else $error("vco range bits did not follow write");
    a_pd_by_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        acfg == pll_cfg_pkg::ACFG_POWER_DOWN && !a_sync_reg |=> outputs_hiz && pll_power_down == 3'h7
            && input_stage_power_down)
        else $error("control a low did not power down");
    a_pd_beats_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        input_stage_power_down |-> !outputs_force_low && outputs_hiz)
        else $error("force-low active during power-down");
    a_test_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
        test_byp && !pd_any |=> full_bypass && !outputs_hiz ##0 pll_power_down == 3'h7)
        else $error("test bypass not applied");
    a_clk_sel_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        src != pll_cfg_pkg::SRC_SINGLE |=> !clock_input_one_sel)
        else $error("input pick active outside single-ended mode");
    a_clk_sel_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        single_mode && acfg == pll_cfg_pkg::ACFG_CLK_SELECT |=> clock_input_one_sel == $past(a_sync_reg))
        else $error("control a did not pick input clock");
    a_ssc_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        b_ssc[pll_cfg_pkg::SSC_MOD_LSB +: 3] == SSC_BYPASS_CODE |=> ssc_power_down && ssc_out_hold_low)
        else $error("spread path not held off under bypass");
endmodule
`default_nettype wire

// *** verif/cfg_host_model.sv ***
// host model driving the byte register port of the configuration block
// assumes ref_clk from the bench; requests launch by nonblocking assignment at rising edges
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
    input wire logic ref_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic reg_rd_single,
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    // ----------------------------------------
    // idle state
    // ----------------------------------------
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_rd_single = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
    end
    // ----------------------------------------
    // transfers
    // ----------------------------------------
    // legal values only
    // callers pick divider, range and selector values; the model does not police them
    task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        // released lines flip so a stale value cannot pass for a held one
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic read_byte(input logic [4:0] a, input logic single, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        reg_rd_single <= single;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        reg_rd_single <= ~single;
        #1;
        v = reg_rd_valid;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the synthesizer configuration block
// assumes the host model owns the register port; the bench drives the two control pins
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [3:0] MAKER = 4'h3;     // arbitrary value
    localparam logic [3:0] REV = 4'hA;       // arbitrary value
    logic ref_clk, rst_n, control_input_a, control_input_b;
    logic reg_wr_en, reg_rd_en, reg_rd_single, reg_rd_valid;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    logic vld;
    logic [26:0] pll_ref_div;
    logic [35:0] pll_fb_div;
    logic [2:0] vco_bypass_bit, vco_range_bit, pll_power_down;
    logic [17:0] postdiv_source_sel;
    logic input_stage_power_down, full_bypass, outputs_hiz, outputs_force_low, clock_input_one_sel;
    logic crystal_mode, differential_mode, ssc_power_down, ssc_out_hold_low;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    pll_synth_config_control #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) pll_synth_config_control_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_rd_single(reg_rd_single), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .control_input_a(control_input_a), .control_input_b(control_input_b),
        .pll_ref_div(pll_ref_div), .pll_fb_div(pll_fb_div), .vco_bypass_bit(vco_bypass_bit),
        .vco_range_bit(vco_range_bit), .postdiv_source_sel(postdiv_source_sel), .pll_power_down(pll_power_down),
        .input_stage_power_down(input_stage_power_down), .full_bypass(full_bypass), .outputs_hiz(outputs_hiz),
        .outputs_force_low(outputs_force_low), .clock_input_one_sel(clock_input_one_sel),
        .crystal_mode(crystal_mode), .differential_mode(differential_mode), .ssc_power_down(ssc_power_down),
        .ssc_out_hold_low(ssc_out_hold_low));
    cfg_host_model cfg_host_model_inst (
        .ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_single(reg_rd_single),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // the whole run needs about 250 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [4:0] a, input logic single, input logic [7:0] exp);
        cfg_host_model_inst.read_byte(a, single, rd, vld);
        check_reg({7'h00, vld}, 8'h01);
        check_reg(rd, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cfg_host_model_inst.write_byte(a, d);
    endtask
    // one edge more than the three the pins need; a write needs only one
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic set_pins(input logic a, input logic b);
        @(posedge ref_clk);
        control_input_a <= a;
        control_input_b <= b;
        settle();
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        control_input_a = 1'b1;
        control_input_b = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        check_out(36'(pll_ref_div), 36'({9'h177, 9'h01B, 9'h001}));
        check_out(pll_fb_div, {12'hC40, 12'h0FA, 12'h008});
        check_out(36'(vco_bypass_bit), 36'h0);
        check_out(36'(vco_range_bit), 36'h7);
        check_out(36'(postdiv_source_sel), 36'h09262);
        check_out(36'({crystal_mode, differential_mode}), 36'h2);
        check_out(36'({ssc_power_down, ssc_out_hold_low}), 36'h3);
        rd_check(5'h03, 1'b1, 8'h00);
        rd_check(5'h06, 1'b1, 8'hE0);
        rd_check(5'h00, 1'b1, {REV, MAKER});
        rd_check(5'h00, 1'b0, 8'h00);
        wr(5'h00, 8'hFF);
        rd_check(5'h00, 1'b1, {REV, MAKER});
        rd_check(5'h1B, 1'b1, 8'h00);
        // top of both divider ranges on pll1, bypass on pll1 and pll3
        wr(5'h01, 8'hFF);
        wr(5'h02, 8'hFF);
        wr(5'h03, 8'hBF);
        settle();
        check_out(36'(pll_ref_div[8:0]), 36'h1FF);
        check_out(36'(pll_fb_div[11:0]), 36'hFFF);
        check_out(36'(vco_bypass_bit), 36'h5);
        rd_check(5'h03, 1'b1, 8'hBF);
        wr(5'h06, 8'h40);
        settle();
        check_out(36'(vco_range_bit), 36'h2);
        check_out(36'(pll_fb_div[23:12]), 36'h0FA);
        wr(5'h04, 8'hC8);
        wr(5'h08, 8'h33);
        settle();
        check_out(36'(pll_ref_div[17:9]), 36'h0C8);
        check_out(36'(pll_fb_div[35:24]), 36'hC33);
        for (int c = 0; c < 5; c++) begin
            wr(5'h09, {3'(c), 5'h19});
            settle();
            check_out(36'(postdiv_source_sel[2:0]), 36'(c));
            rd_check(5'h09, 1'b1, {3'(c), 5'h19});
        end
        wr(5'h19, 8'h10);
        settle();
        check_out(36'({ssc_power_down, ssc_out_hold_low}), 36'h0);
        wr(5'h19, 8'h00);
        settle();
        check_out(36'({ssc_power_down, ssc_out_hold_low}), 36'h3);
        // power-down with a low, b low asking for forced-low outputs at the same time
        set_pins(1'b0, 1'b0);
        check_out(36'({pll_power_down, input_stage_power_down}), 36'hF);
        check_out(36'({outputs_hiz, outputs_force_low, full_bypass}), 36'h4);
        rd_check(5'h03, 1'b1, 8'hBF);
        set_pins(1'b1, 1'b1);
        check_out(36'({pll_power_down, outputs_hiz, outputs_force_low}), 36'h0);
        wr(5'h0A, 8'h81);
        set_pins(1'b0, 1'b1);
        check_out(36'({full_bypass, outputs_hiz, input_stage_power_down}), 36'h4);
        set_pins(1'b1, 1'b1);
        check_out(36'(full_bypass), 36'h0);
        // register picks input one, pin low overrides it to zero, pin high keeps input one
        wr(5'h0B, 8'h49);
        wr(5'h0A, 8'h92);
        set_pins(1'b0, 1'b1);
        check_out(36'(clock_input_one_sel), 36'h0);
        set_pins(1'b1, 1'b1);
        check_out(36'(clock_input_one_sel), 36'h1);
        check_out(36'({crystal_mode, differential_mode}), 36'h0);
        wr(5'h0B, 8'h89);
        settle();
        check_out(36'({crystal_mode, differential_mode}), 36'h1);
        check_out(36'(clock_input_one_sel), 36'h0);
        wr(5'h0B, 8'h09);
        settle();
        check_out(36'({crystal_mode, differential_mode}), 36'h2);
        // control b low without power-down: forced low first, then hi-z
        set_pins(1'b1, 1'b0);
        check_out(36'({outputs_hiz, outputs_force_low}), 36'h1);
        wr(5'h0A, 8'h96);
        settle();
        check_out(36'({outputs_hiz, outputs_force_low}), 36'h2);
        for (int i = 13; i < 27; i++) begin
            wr(5'(i), 8'h80 | 8'(i));
            rd_check(5'(i), 1'b1, 8'h80 | 8'(i));
        end
        for (int i = 13; i < 27; i++) begin
            rd_check(5'(i), 1'b1, 8'h80 | 8'(i));
        end
        complete_run();
    end
endmodule
`default_nettype wire
